// ### hw/fas_scan_seq.sv
// Scan sequencer for the four-channel isolated analog input submodule
// Notes on behaviour
// - Free-run: scan four channels forever, results readable
// - Free-run scan unrelated to host reads
// - Strap selects synchronous mode
// - Sync: halt after full pass, hold results
// - Sync: channel 4 read starts new pass
// - Each conversion 200 us, pass 800 us
// - 12-bit results left-justified in 16 bits
// - Bipolar results in two's complement
`timescale 1ns/1ps
`default_nettype none
module fas_scan_seq #(
   parameter int CONV_CYC = fas_pkg::CONV_CYCLES,  // Cycles per conversion
   parameter int ADC_BITS = 16                     // 12 or 16 bit variant
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     sync_mode_strap,   // Raw strap pin
   input  wire logic                     bipolar_strap,     // Raw range strap pin
   input  wire logic                     rd_strobe,         // Host read, one cycle
   input  wire logic [1:0]               rd_chan,           // Channel being read
   input  wire fas_pkg::fas_conv_rsp_type conv_rsp,         // Converter answer
   output var  fas_pkg::fas_conv_req_type conv_req,         // Converter request
   output var  logic [15:0]              rd_data,           // Read result
   output var  logic                     pass_done          // Sync pass complete
);
   import fas_pkg::*;

   localparam int CNT_W = $clog2(CONV_CYC + 1);               // Timer width
   // Final count; the start cycle plus the counts 0 to this fill exactly one conversion period
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYC - 2);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;               // Timer start

   // Strap synchronisers, first stage read only by second
   logic [1:0] sync_s_q;
   logic [1:0] bip_s_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_s_q <= 2'h0;
         bip_s_q  <= 2'h0;
      end else begin
         sync_s_q <= {sync_s_q[0], sync_mode_strap};
         bip_s_q  <= {bip_s_q[0], bipolar_strap};
      end
   end
   wire logic sync_mode = sync_s_q[1];   // Qualified strap level
   wire logic bipolar   = bip_s_q[1];    // Qualified range level

   // Sequencer state
   fas_state_type    state_q, state_d;
   logic [1:0]       chan_q, chan_d;     // Channel in conversion
   logic [CNT_W-1:0] cnt_q, cnt_d;       // Conversion timer
   logic             start_q, start_d;   // Converter start pulse
   logic             done_q, done_d;     // Pass complete flag
   logic             rearm_q, rearm_d;   // Channel 4 read seen

   // Formatting of a raw code into the host word
   function automatic logic [15:0] fmt(input logic [15:0] raw, input logic bip);
      logic [15:0] w;
      w = raw << (RES_W - ADC_BITS);     // Left-justify narrow variant
      if (bip) begin
         // Offset binary to two's complement: flip the sign bit
         w = {~w[15], w[14:0]};
      end
      return w;
   endfunction

   // Next-state logic of the scan
   always_comb begin
      state_d = state_q;
      chan_d  = chan_q;
      cnt_d   = cnt_q;
      start_d = 1'b0;
      done_d  = done_q;
      // Read of channel 4 re-arms; set wins over the clear below
      rearm_d = rearm_q | (rd_strobe && rd_chan == LAST_CH);
      case (state_q)
         FAS_IDLE: begin
            state_d = FAS_START;
            chan_d  = FIRST_CH;
         end
         FAS_START: begin
            start_d = 1'b1;
            cnt_d   = CNT_ZERO;
            state_d = FAS_WAIT;
         end
         FAS_WAIT: begin
            // Fixed dwell per channel, independent of host reads
            if (cnt_q == CNT_LAST) begin
               if (chan_q == LAST_CH) begin
                  if (sync_mode) begin   // Strap picks the mode
                     state_d = FAS_HOLD; // Halt after full pass
                     done_d  = 1'b1;
                     rearm_d = rd_strobe && rd_chan == LAST_CH;
                  end else begin
                     chan_d  = FIRST_CH; // Wrap and keep scanning
                     state_d = FAS_START;
                  end
               end else begin
                  chan_d  = chan_q + 2'h1; // Fixed ascending order
                  state_d = FAS_START;
               end
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         FAS_HOLD: begin
            // Stay until channel 4 is read, or the strap is released
            if (rearm_q || !sync_mode) begin
               state_d = FAS_START;   // New pass
               chan_d  = FIRST_CH;
               done_d  = 1'b0;
               // A coinciding channel 4 read still sets the flag
               rearm_d = rd_strobe && rd_chan == LAST_CH;
            end
         end
         default: begin
            state_d = FAS_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= FAS_IDLE;
         chan_q  <= FIRST_CH;
         cnt_q   <= CNT_ZERO;
         start_q <= 1'b0;
         done_q  <= 1'b0;
         rearm_q <= 1'b0;
      end else begin
         state_q <= state_d;
         chan_q  <= chan_d;
         cnt_q   <= cnt_d;
         start_q <= start_d;
         done_q  <= done_d;
         rearm_q <= rearm_d;
      end
   end

   // Holding registers, one per channel
   logic [15:0] hold_q [NUM_CH];
   logic [15:0] hold_d [NUM_CH];
   for (genvar i = 0; i < NUM_CH; i++) begin : g_hold
      // Capture on completion of this channel's conversion
      always_comb begin
         hold_d[i] = hold_q[i];
         if (conv_rsp.done && chan_q == 2'(i) && state_q == FAS_WAIT) begin
            hold_d[i] = fmt(conv_rsp.data, bipolar);
         end
      end
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            hold_q[i] <= RESULT_RST;
         end else begin
            hold_q[i] <= hold_d[i];
         end
      end
   end

   // Read data register, latest value of the addressed channel
   logic [15:0] rd_q, rd_d;
   always_comb begin
      rd_d = hold_q[rd_chan];   // Always available to read
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= RESULT_RST;
      end else begin
         rd_q <= rd_d;
      end
   end

   assign conv_req       = '{start: start_q, chan: chan_q};
   assign rd_data        = rd_q;
   assign pass_done      = done_q;

   // Timer stays within one conversion
   property p_cnt_bound;
      @(posedge clk) disable iff (!rst_n) cnt_q <= CNT_LAST;
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("timer overran");

   // Start pulse is a single cycle
   property p_start_pulse;
      @(posedge clk) disable iff (!rst_n) start_q |=> !start_q;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");

   // Channel advances by one after a conversion
   property p_order;
      @(posedge clk) disable iff (!rst_n)
         (state_q == FAS_WAIT && cnt_q == CNT_LAST && chan_q != LAST_CH)
         |=> chan_q == $past(chan_q) + 2'h1;
   endproperty
   a_order: assert property (p_order) else $error("channel order broken");

   // Free-run wraps to channel 1
   property p_wrap;
      @(posedge clk) disable iff (!rst_n)
         (state_q == FAS_WAIT && cnt_q == CNT_LAST && chan_q == LAST_CH && !sync_mode)
         |=> state_q == FAS_START && chan_q == FIRST_CH;
   endproperty
   a_wrap: assert property (p_wrap) else $error("free-run did not wrap");

   // Sync mode halts after the last channel
   property p_halt;
      @(posedge clk) disable iff (!rst_n)
         (state_q == FAS_WAIT && cnt_q == CNT_LAST && chan_q == LAST_CH && sync_mode)
         |=> state_q == FAS_HOLD && pass_done;
   endproperty
   a_halt: assert property (p_halt) else $error("sync pass did not halt");

   // No conversion while holding
   property p_hold_quiet;
      @(posedge clk) disable iff (!rst_n) state_q == FAS_HOLD |-> !start_q;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("start in hold");

   // Channel 4 read in hold restarts within three cycles
   property p_restart;
      @(posedge clk) disable iff (!rst_n)
         (state_q == FAS_HOLD && rd_strobe && rd_chan == LAST_CH)
         |-> ##[1:3] start_q;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart on read");

   // Read data follows the addressed holding register
   property p_read;
      @(posedge clk) disable iff (!rst_n)
         1'b1 |=> rd_data == $past(hold_q[rd_chan]);
   endproperty
   a_read: assert property (p_read) else $error("read data mismatch");
endmodule
`default_nettype wire

// ### hw/fas_pkg.sv
// Package for the four-channel scan sequencer: constants, types and timing
package fas_pkg;
   localparam int          NUM_CH        = 4;       // Channels scanned per pass
   localparam int          RES_W         = 16;      // Host-visible result word
   localparam int          CONV_TIME_US  = 200;     // One conversion, microseconds
   localparam int          CLK_MHZ       = 200;     // Clock rate
   localparam int          CONV_CYCLES   = CONV_TIME_US * CLK_MHZ;  // 40000 cycles
   localparam int          STALE_MAX_US  = 1000;    // Oldest value in free-run
   localparam logic [1:0]  LAST_CH       = 2'h3;    // Index of channel 4
   localparam logic [1:0]  FIRST_CH      = 2'h0;    // Index of channel 1
   localparam logic [15:0] RESULT_RST    = 16'h0000; // Holding register reset

   // Converter handshake toward the analog front end
   typedef struct packed {
      logic        start;     // Start a conversion
      logic [1:0]  chan;      // Channel being converted
   } fas_conv_req_type;

   // Result returned by the converter
   typedef struct packed {
      logic        done;      // Conversion finished
      logic [15:0] data;      // Raw code, right justified
   } fas_conv_rsp_type;

   // Sequencer states, Gray along the usual path
   typedef enum logic [1:0] {
      FAS_IDLE  = 2'b00,
      FAS_START = 2'b01,
      FAS_WAIT  = 2'b11,
      FAS_HOLD  = 2'b10
   } fas_state_type;
endpackage

// ### verif/fas_conv_model.sv
// Behavioural converter front end answering the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module fas_conv_model #(
   parameter int DLY = 5                        // Start to done, inside window
) (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire fas_pkg::fas_conv_req_type conv_req,
   output var  fas_pkg::fas_conv_rsp_type conv_rsp
);
   import fas_pkg::*;
   int         cnt_q;                           // Cycles left until done
   logic [1:0] chan_q;                          // Channel latched at start
   // Count down from each start and answer once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= 0;
         chan_q <= 2'h0;
      end else if (conv_req.start) begin
         cnt_q  <= DLY;
         chan_q <= conv_req.chan;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
   // Done lands inside the conversion window
   // Data churns outside done, so nothing can lean on a stale code
   assign conv_rsp = '{done: (cnt_q == 1),
                       data: (cnt_q == 1) ? 16'h4C10 + 16'(chan_q)
                                          : 16'(cnt_q) ^ 16'hA5A5};
endmodule
`default_nettype wire

// ### verif/fas_scan_seq_test.sv
// Self-checking testbench for the four-channel scan sequencer
`timescale 1ns/1ps
`default_nettype none
module fas_scan_seq_test;
   import fas_pkg::*;
   localparam int    CC = 20;                   // Shortened conversion window
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   logic             sync_mode_strap = 1'b0;
   logic             bipolar_strap = 1'b0;
   logic             rd_strobe = 1'b0;
   logic [1:0]       rd_chan = 2'h0;
   fas_conv_rsp_type conv_rsp;
   fas_conv_req_type conv_req;
   logic [15:0]      rd_data;
   logic [15:0]      rd_data_nrw;               // Result word of the 12-bit variant
   logic             pass_done;
   int               error_cnt = 0;
   int               num_checks = 0;
   int               cyc = 0;                   // Cycle count, also the timeout
   always #2.5 clk = ~clk;
   // Cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         finish_test();
      end
   end
   fas_scan_seq #(.CONV_CYC(CC), .ADC_BITS(16)) i_fas_scan_seq (.clk(clk), .rst_n(rst_n),
      .sync_mode_strap(sync_mode_strap), .bipolar_strap(bipolar_strap), .rd_strobe(rd_strobe),
      .rd_chan(rd_chan), .conv_rsp(conv_rsp), .conv_req(conv_req), .rd_data(rd_data),
      .pass_done(pass_done));
   // Narrow variant runs in lockstep on the same converter answers
   fas_scan_seq #(.CONV_CYC(CC), .ADC_BITS(12)) i_fas_scan_seq_nrw (.clk(clk), .rst_n(rst_n),
      .sync_mode_strap(sync_mode_strap), .bipolar_strap(bipolar_strap), .rd_strobe(rd_strobe),
      .rd_chan(rd_chan), .conv_rsp(conv_rsp), .conv_req(), .rd_data(rd_data_nrw),
      .pass_done());
   fas_conv_model #(.DLY(5)) i_fas_conv_model (.clk(clk), .rst_n(rst_n),
      .conv_req(conv_req), .conv_rsp(conv_rsp));
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Poll for a start pulse, bounded
   task automatic wait_start(input int lim, output int ok);
      ok = 0;
      for (int i = 0; i < lim && ok == 0; i++) begin
         @(posedge clk);
         #1;
         if (conv_req.start === 1'b1) ok = 1;
      end
   endtask
   // Free-run order, spacing and wrap over two passes
   task automatic t_order();
      int ok;
      int t0;
      wait_start(3 * CC, ok);
      check(16'(ok), 16'h1);
      check({14'h0, conv_req.chan}, 16'h0);
      for (int k = 1; k < 9; k++) begin
         t0 = cyc;
         wait_start(2 * CC, ok);
         check(16'(cyc - t0), 16'(CC));
         check({14'h0, conv_req.chan}, 16'(k % 4));
      end
      $display("test order done");
   endtask
   // Read every channel in order, unipolar then bipolar
   task automatic t_read();
      for (int b = 0; b < 2; b++) begin
         @(posedge clk) bipolar_strap <= b[0];
         repeat (5 * (CC + 1)) @(posedge clk);
         for (int k = 0; k < 4; k++) begin
            @(posedge clk) rd_chan <= 2'(k);
            @(posedge clk);
            #1;
            check(rd_data, (16'h4C10 + 16'(k)) ^ {b[0], 15'h0});
            check(rd_data_nrw, {12'hC10 + 12'(k), 4'h0} ^ {b[0], 15'h0});
         end
      end
      $display("test read done");
   endtask
   // Sync halt, wrong-channel read, channel 4 restart, strap release
   task automatic t_sync();
      int ok;
      @(posedge clk) sync_mode_strap <= 1'b1;
      for (int i = 0; i < 6 * (CC + 1) && pass_done !== 1'b1; i++) @(posedge clk);
      #1;
      check(16'(pass_done), 16'h1);
      wait_start(3 * CC, ok);
      check(16'(ok), 16'h0);
      for (int c = 0; c < 2; c++) begin
         @(posedge clk) begin
            rd_chan <= c[0] ? 2'h3 : 2'h0;
            rd_strobe <= 1'b1;
         end
         @(posedge clk) rd_strobe <= 1'b0;
         wait_start(6, ok);
         check(16'(ok), 16'(c));
      end
      check({14'h0, conv_req.chan}, 16'h0);
      @(posedge clk);
      #1;
      check(16'(pass_done), 16'h0);
      for (int i = 0; i < 6 * (CC + 1) && pass_done !== 1'b1; i++) @(posedge clk);
      @(posedge clk) sync_mode_strap <= 1'b0;
      wait_start(10, ok);
      check(16'(ok), 16'h1);
      $display("test sync done");
   endtask
   // Print counts and verdict, then stop
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_order();
      t_read();
      t_sync();
      finish_test();
   end
endmodule
`default_nettype wire
